// File: design/conditioner_consts.vh
`ifndef CONDITIONER_CONSTS_VH
`define CONDITIONER_CONSTS_VH
`define CLK_PERIOD_NS 25
`define I2C_ADDR 7'h2C
`define CHIRP_MIN_US 18
`define CHIRP_MAX_US 128
`define CHIRP_MIN_CYC ((`CHIRP_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHIRP_MAX_CYC ((`CHIRP_MAX_US * 1000) / `CLK_PERIOD_NS)
`define CHIRP_CNT_W 13
`define SENS_LOW 2'h0
`define SENS_MED 2'h1
`define SENS_HIGH 2'h2
`define BOOST_FLOAT_LEVEL 2'h3
`define LINE_SE0 2'h0
`define LINE_J 2'h1
`define LINE_K 2'h2
`endif

// File: design/conditioner_ctrl.v
`timescale 1ns/1ps
`include "conditioner_consts.vh"
module conditioner_ctrl (
    input wire i_clk, // Internal free-running clock, 40 MHz
    input wire i_rst, // Power-on reset, sync, active high
    input wire i_device_enable_n, // Enable pin, low keeps device in reset
    input wire i_sda, // Data pin level
    input wire i_scl, // Clock pin level
    input wire [1:0] i_sens_level, // Sensitivity pin: 0 low,1 float,2 high
    input wire [1:0] i_boost_level, // Boost strap level decoded from pin
    input wire i_boost_float, // Boost strap pin is floating
    input wire [1:0] i_line_state, // Port line state: SE0, J, K
    input wire i_pullup_seen, // Pull-up seen on either data line
    input wire i_disconnect, // Disconnect detected
    input wire i_bus_reset, // USB bus reset seen
    input wire i_fixture_seen, // Compliance fixture detected
    input wire i_test_packet, // Test packet pattern seen
    input wire i_squelch, // Squelch detected
    input wire [1:0] i_edge_boost_reg, // Edge boost from management regs
    input wire [1:0] i_dc_boost_reg, // DC boost from management regs
    output reg o_mgmt_mode, // Management mode selected
    output reg [6:0] o_target_addr, // Management target address
    output reg [1:0] o_rx_sensitivity, // Latched sensitivity setting
    output reg [1:0] o_edge_boost, // Edge boost level in use
    output reg [1:0] o_dc_boost, // DC boost level in use
    output reg o_shutdown, // Shutdown active
    output reg o_high_speed_active_flag, // High-speed flag value
    output reg o_hs_flag_oe, // Sensitivity pin drive enable
    output reg o_attach_detected_flag, // Attach flag value
    output reg o_attach_oe // Clock pin drive enable
);

////////////////////////////////////////////////////////////////////////
// Overview
// Every pin level arrives from the analog front end asynchronously.
// Each one passes a two-stage synchroniser before any logic reads it.
// That costs two cycles of latency, which is far below the chirp window,
// so the handshake timing is not disturbed in practice.
// Mode and boost straps are taken once, at the first edge after
// power-on reset. Outside management mode the sensitivity strap follows the pin for as long as the
// enable pin holds the device in reset, and freezes when the device runs.
// Both flags are levels. They are cleared while the device is held in
// reset. In management mode they are driven only in its first cycle, if the enable pin is already high.
// Limitation: the handshake needs the attach flag first. A bus reset seen
// before attach is ignored.

////////////////////////////////////////////////////////////////////////
// Boost strap decode; a floating strap selects the top level
function [1:0] strap_boost;
    input [1:0] level; // Decoded resistor level
    input float; // Pin left open
    begin
        strap_boost = float ? `BOOST_FLOAT_LEVEL : level;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Synchronisers for all pin inputs
reg [1:0] en_s, sda_s, scl_s, pu_s, dis_s, br_s, fx_s, tp_s, sq_s;
reg [1:0] sens_a, sens_b, lst_a, lst_b;
reg [1:0] bl_a, bl_b; // Boost level synchroniser
reg [1:0] bf_s; // Boost float synchroniser
always @(posedge i_clk) begin
    en_s <= {en_s[0], i_device_enable_n};
    sda_s <= {sda_s[0], i_sda};
    scl_s <= {scl_s[0], i_scl};
    pu_s <= {pu_s[0], i_pullup_seen};
    dis_s <= {dis_s[0], i_disconnect};
    br_s <= {br_s[0], i_bus_reset};
    fx_s <= {fx_s[0], i_fixture_seen};
    tp_s <= {tp_s[0], i_test_packet};
    sq_s <= {sq_s[0], i_squelch};
    sens_a <= i_sens_level;
    sens_b <= sens_a;
    lst_a <= i_line_state;
    lst_b <= lst_a;
    // Straps are static, but still pins: sync them like the rest
    bl_a <= i_boost_level;
    bl_b <= bl_a;
    bf_s <= {bf_s[0], i_boost_float};
end

// Device held in reset by power-on or enable pin low
wire run = ~i_rst & en_s[1];

////////////////////////////////////////////////////////////////////////
// Power-up strap capture, once only; later pin changes are ignored
reg captured; // Straps already taken
always @(posedge i_clk) begin
    if (i_rst) begin
        captured <= 1'b0;
        o_mgmt_mode <= 1'b0;
        o_target_addr <= 7'h00;
        o_edge_boost <= 2'h0;
        o_dc_boost <= 2'h0;
    end else if (!captured) begin
        captured <= 1'b1;
        o_mgmt_mode <= sda_s[1] & scl_s[1];
        o_target_addr <= `I2C_ADDR;
        // Floating strap picks level 3; one strap sets both boosts
        o_edge_boost <= strap_boost(bl_b, bf_s[1]);
        o_dc_boost <= strap_boost(bl_b, bf_s[1]);
    end else if (o_mgmt_mode) begin
        // Separate boosts only under management control
        o_edge_boost <= i_edge_boost_reg;
        o_dc_boost <= i_dc_boost_reg;
    end
end

////////////////////////////////////////////////////////////////////////
// Sensitivity strap: tracked while the enable pin holds the device in reset outside management mode, frozen at release
always @(posedge i_clk) begin
    if (i_rst) begin
        o_rx_sensitivity <= `SENS_MED;
    end else if (!run && !o_mgmt_mode) begin
        o_rx_sensitivity <= sens_b;
    end
end

////////////////////////////////////////////////////////////////////////
// Chirp handshake: one J then one K, each within the time window
localparam HS_IDLE = 3'd0; // Waiting for bus reset
localparam HS_WAIT_J = 3'd1; // Bus reset seen, waiting chirp J
localparam HS_IN_J = 3'd2; // Timing chirp J
localparam HS_WAIT_K = 3'd3; // Waiting chirp K
localparam HS_IN_K = 3'd4; // Timing chirp K
localparam HS_DONE = 3'd5; // Handshake good, wait squelch
reg [2:0] hs_state;
reg [`CHIRP_CNT_W-1:0] chirp_cnt; // Chirp length counter
// Counter saturates so a stuck line cannot wrap into the window
wire chirp_ok = (chirp_cnt >= `CHIRP_MIN_CYC) && (chirp_cnt <= `CHIRP_MAX_CYC);
always @(posedge i_clk) begin
    if (!run || o_mgmt_mode || !o_attach_detected_flag) begin
        hs_state <= HS_IDLE;
        chirp_cnt <= {`CHIRP_CNT_W{1'b0}};
    end else begin
        if (chirp_cnt != {`CHIRP_CNT_W{1'b1}}) begin
            chirp_cnt <= chirp_cnt + 1'b1;
        end
        case (hs_state)
            HS_IDLE: begin
                if (br_s[1]) begin
                    hs_state <= HS_WAIT_J;
                end
            end
            HS_WAIT_J: begin
                chirp_cnt <= {`CHIRP_CNT_W{1'b0}};
                if (lst_b == `LINE_J) begin
                    hs_state <= HS_IN_J;
                end
            end
            HS_IN_J: begin
                if (lst_b != `LINE_J) begin
                    // Chirp out of window restarts the handshake
                    hs_state <= (chirp_ok && lst_b == `LINE_K) ? HS_IN_K : HS_IDLE;
                    chirp_cnt <= {`CHIRP_CNT_W{1'b0}};
                end
            end
            HS_IN_K: begin
                if (lst_b != `LINE_K) begin
                    hs_state <= chirp_ok ? HS_DONE : HS_IDLE;
                end
            end
            HS_DONE: begin
                hs_state <= HS_DONE;
            end
            default: begin
                hs_state <= HS_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Attach flag and compliance fixture tracking
reg fixture_armed; // Fixture seen while unconnected
always @(posedge i_clk) begin
    if (!run || o_mgmt_mode) begin
        o_attach_detected_flag <= 1'b0;
        fixture_armed <= 1'b0;
    end else begin
        if (!o_attach_detected_flag) begin
            if (pu_s[1]) begin
                o_attach_detected_flag <= 1'b1;
            end
            if (fx_s[1]) begin
                fixture_armed <= 1'b1;
            end
        end else if (dis_s[1]) begin
            o_attach_detected_flag <= 1'b0;
            fixture_armed <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// High-speed flag, sticky until reset, or until disconnect unless the fixture is armed or squelch is still seen
always @(posedge i_clk) begin
    if (!run || o_mgmt_mode) begin
        o_high_speed_active_flag <= 1'b0;
    end else if (fixture_armed && tp_s[1]) begin
        o_high_speed_active_flag <= 1'b1;
    end else if (hs_state == HS_DONE && sq_s[1]) begin
        o_high_speed_active_flag <= 1'b1;
    end else if (o_attach_detected_flag && dis_s[1] && !fixture_armed) begin
        o_high_speed_active_flag <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Pin drive enables and shutdown
always @(posedge i_clk) begin
    if (i_rst) begin
        o_hs_flag_oe <= 1'b0;
        o_attach_oe <= 1'b0;
        o_shutdown <= 1'b1;
    end else begin
        o_shutdown <= ~en_s[1];
        o_hs_flag_oe <= run & ~o_mgmt_mode;
        o_attach_oe <= run & ~o_mgmt_mode;
    end
end

endmodule

// File: bench/cond_partner.sv
`timescale 1ns/1ps
// Far side: port lines and detector levels as the analog front end reports them
module cond_partner (
    input wire i_clk, // Bench clock
    output reg [1:0] o_line_state, // SE0, J or K
    output reg o_pullup_seen, // Pull-up present
    output reg o_disconnect, // Disconnect seen
    output reg o_bus_reset, // Bus reset seen
    output reg o_fixture_seen, // Fixture present
    output reg o_test_packet, // Test packet on line
    output reg o_squelch // Squelch seen
);
    initial {o_line_state, o_pullup_seen, o_disconnect, o_bus_reset} = 5'h0;
    initial {o_fixture_seen, o_test_packet, o_squelch} = 3'h0;
    task hold(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    task attach;
        o_disconnect <= 1'b0;
        o_pullup_seen <= 1'b1;
        hold(6);
    endtask
    task detach;
        {o_pullup_seen, o_squelch} <= 2'h0;
        o_disconnect <= 1'b1;
        hold(6);
        o_disconnect <= 1'b0;
        hold(1);
    endtask
    // Reset, chirp J then K, idle, squelch; lengths in cycles
    task handshake(input integer j, input integer k);
        o_bus_reset <= 1'b1;
        hold(4);
        o_bus_reset <= 1'b0;
        o_line_state <= 2'h1;
        hold(j);
        o_line_state <= 2'h2;
        hold(k);
        o_line_state <= 2'h0;
        hold(4);
        o_squelch <= 1'b1;
        hold(6);
    endtask
    // Fixture seen while unconnected, then test packet
    task fixture;
        o_fixture_seen <= 1'b1;
        hold(4);
        o_test_packet <= 1'b1;
        hold(6);
        {o_fixture_seen, o_test_packet} <= 2'h0;
        hold(1);
    endtask
endmodule

// File: bench/cond_assertions.sv
`timescale 1ns/1ps
module cond_assertions (
    input wire i_clk, // Clock
    input wire i_rst, // Reset
    input wire i_device_enable_n, // Enable, low off
    input wire i_pullup_seen, // Pull-up
    input wire i_disconnect, // Disconnect
    input wire i_squelch, // Squelch
    input wire i_test_packet, // Test packet
    input wire o_mgmt_mode, // Mode
    input wire [6:0] o_target_addr, // Address
    input wire o_shutdown, // Shutdown
    input wire o_high_speed_active_flag, // HS flag
    input wire o_hs_flag_oe, // HS drive
    input wire o_attach_detected_flag, // Attach flag
    input wire o_attach_oe // Attach drive
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_enable_low;
        !i_device_enable_n [*4];
    endsequence
    a_mgmt_no_attach: assert property (o_mgmt_mode |-> !o_attach_oe)
        else $error("attach drive in management mode");
    a_mgmt_no_hs: assert property (o_mgmt_mode |-> !o_hs_flag_oe)
        else $error("hs drive in management mode");
    a_addr_fixed: assert property (o_mgmt_mode |-> o_target_addr == 7'h2C)
        else $error("target address wrong");
    a_attach_cause: assert property ($rose(o_attach_detected_flag) |-> $past(i_pullup_seen, 3))
        else $error("attach flag without pull-up");
    a_disc_clear: assert property ($rose(i_disconnect) |-> ##[2:4] !o_attach_detected_flag)
        else $error("attach flag kept after disconnect");
    a_hs_cause: assert property ($rose(o_high_speed_active_flag)
        |-> $past(i_squelch || i_test_packet, 3))
        else $error("hs flag without cause");
    a_enable_off: assert property (s_enable_low |=> o_shutdown && !o_attach_oe && !o_hs_flag_oe)
        else $error("not shut down while disabled");
    a_reset_clear: assert property ($fell(i_rst) |-> !o_attach_detected_flag
        && !o_high_speed_active_flag)
        else $error("flags set after reset");
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg i_clk = 0, i_rst = 1, en_n = 0, pin = 0;
    reg [1:0] sens = 2'h0;
    wire [1:0] ls, rs, eb, db;
    wire pu, dis, br, fx, tp, sq, mg, sd, hs, hoe, at, aoe;
    wire [6:0] ad;
    integer miscompares = 0, total_checks = 0, s;
    always #12.5 i_clk = ~i_clk;
    cond_partner u_cond_partner (.i_clk(i_clk), .o_line_state(ls), .o_pullup_seen(pu),
        .o_disconnect(dis), .o_bus_reset(br), .o_fixture_seen(fx), .o_test_packet(tp),
        .o_squelch(sq));
    conditioner_ctrl u_conditioner_ctrl (.i_clk(i_clk), .i_rst(i_rst),
        .i_device_enable_n(en_n), .i_sda(pin), .i_scl(pin), .i_sens_level(sens),
        .i_boost_level(2'h1), .i_boost_float(1'b1), .i_line_state(ls), .i_pullup_seen(pu),
        .i_disconnect(dis), .i_bus_reset(br), .i_fixture_seen(fx), .i_test_packet(tp),
        .i_squelch(sq), .i_edge_boost_reg(2'h0), .i_dc_boost_reg(2'h0), .o_mgmt_mode(mg),
        .o_target_addr(ad), .o_rx_sensitivity(rs), .o_edge_boost(eb), .o_dc_boost(db),
        .o_shutdown(sd), .o_high_speed_active_flag(hs), .o_hs_flag_oe(hoe),
        .o_attach_detected_flag(at), .o_attach_oe(aoe));
    task chk(input [10:0] g, input [10:0] e, input [8*6:1] n);
        total_checks = total_checks + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("Error %0s expected %h seen %h", n, e, g);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Straps held for the whole reset, enable low until released
    task restart(input m, input [1:0] v);
        {i_rst, en_n, pin, sens} <= {2'b10, m, v};
        repeat (4) @(posedge i_clk);
        {i_rst, en_n} <= 2'b01;
        repeat (6) @(posedge i_clk);
    endtask
    initial begin
        @(posedge i_clk);
        for (s = 0; s < 3; s = s + 1) begin
            restart(0, s[1:0]);
            chk(rs, s[1:0], "sens");
            chk({mg, sd, eb, db}, 6'h0F, "straps");
        end
        $display("test straps done");
        u_cond_partner.attach;
        chk({at, aoe, hoe}, 3'h7, "attach");
        u_cond_partner.handshake(1000, 1000);
        chk(hs, 1, "hs");
        u_cond_partner.detach;
        chk({at, hs}, 0, "detach");
        u_cond_partner.attach;
        u_cond_partner.handshake(600, 1000);
        chk(hs, 0, "short");
        u_cond_partner.detach;
        u_cond_partner.fixture;
        chk(hs, 1, "fixtr");
        u_cond_partner.attach;
        en_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        chk({at, hs, sd}, 3'h1, "enable");
        $display("test flags done");
        restart(1, 2'h2);
        u_cond_partner.attach;
        chk({mg, ad, aoe, hoe, at}, 11'h560, "mgmt");
        chk({eb, db}, 4'h0, "mboost");
        $display("test mgmt done");
        stop_test;
    end
    initial begin
        #1000000;
        miscompares = miscompares + 1;
        stop_test;
    end
endmodule
bind conditioner_ctrl cond_assertions u_cond_assertions (.i_clk(i_clk), .i_rst(i_rst),
    .i_device_enable_n(i_device_enable_n), .i_pullup_seen(i_pullup_seen),
    .i_disconnect(i_disconnect), .i_squelch(i_squelch), .i_test_packet(i_test_packet),
    .o_mgmt_mode(o_mgmt_mode), .o_target_addr(o_target_addr), .o_shutdown(o_shutdown),
    .o_high_speed_active_flag(o_high_speed_active_flag), .o_hs_flag_oe(o_hs_flag_oe),
    .o_attach_detected_flag(o_attach_detected_flag), .o_attach_oe(o_attach_oe));
